//--- omr_regs.sv
// Management register bank with two-wire serial target and sideband pins
`timescale 1ns/1ps
module omr_regs #(
	parameter int INIT_CYC = omr_pkg::INIT_CYCLES,
	parameter logic [6:0] DEV_ADDRESS = omr_pkg::DEV_ADDR
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic link_clk,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic module_select_n,
	input wire logic module_reset_n,
	input wire logic low_power_select,
	output logic presence_out,
	output logic presence_oe,
	output logic interrupt_out,
	output logic interrupt_oe,
	input wire logic [3:0] tx_los_in,
	input wire logic [3:0] rx_los_in,
	input wire logic [3:0] tx_lol_in,
	input wire logic [3:0] rx_lol_in,
	input wire logic [3:0] tx_fault_in,
	output logic [3:0] tx_laser_on,
	output logic [3:0] rx_output_on,
	output logic high_power_on,
	output logic upper_class_on
);
	// ************************************************************
	// Link domain: reset, pin synchronisers
	// ************************************************************
	logic [1:0] l_rst_s;
	logic l_rst_n;
	logic scl_a, scl_b, scl_c;
	logic sda_a, sda_b, sda_c;
	logic sel_a, sel_b;
	logic s_rise, s_fall, start_c, stop_c;

	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			l_rst_s <= 2'h0;
		end else begin
			l_rst_s <= {l_rst_s[0], 1'b1};
		end
	end
	assign l_rst_n = l_rst_s[1];

	always_ff @(posedge link_clk or negedge l_rst_n) begin
		if (!l_rst_n) begin
			scl_a <= 1'b1;
			scl_b <= 1'b1;
			scl_c <= 1'b1;
			sda_a <= 1'b1;
			sda_b <= 1'b1;
			sda_c <= 1'b1;
			sel_a <= 1'b1;
			sel_b <= 1'b1;
		end else begin
			scl_a <= scl_in;
			scl_b <= scl_a;
			scl_c <= scl_b;
			sda_a <= sda_in;
			sda_b <= sda_a;
			sda_c <= sda_b;
			sel_a <= module_select_n;
			sel_b <= sel_a;
		end
	end

	assign s_rise = scl_b & ~scl_c;
	assign s_fall = ~scl_b & scl_c;
	assign start_c = scl_b & scl_c & sda_c & ~sda_b;
	assign stop_c = scl_b & scl_c & ~sda_c & sda_b;

	// ************************************************************
	// Link domain: byte engine
	// ************************************************************
	omr_pkg::omr_state_t st;
	logic [3:0] cnt;
	logic [7:0] sh;
	logic rw, first;
	logic [7:0] ptr;
	logic l_req;
	logic l_we;
	logic [7:0] l_addr;
	logic [7:0] l_wdata;
	logic ak_a, ak_b;
	logic c_ack;
	logic rd_ok;
	logic [7:0] c_rdata;

	always_ff @(posedge link_clk or negedge l_rst_n) begin
		if (!l_rst_n) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	// Returned acknowledge marks c_rdata as settled for the latest request
	always_ff @(posedge link_clk or negedge l_rst_n) begin
		if (!l_rst_n) begin
			ak_a <= 1'b0;
			ak_b <= 1'b0;
		end else begin
			ak_a <= c_ack;
			ak_b <= ak_a;
		end
	end
	// An unanswered fetch sends ones, the released level, never a torn word
	assign rd_ok = ~(ak_b ^ l_req);

	// Read data is fetched one SCL phase ahead; no clock stretching is done
	always_ff @(posedge link_clk or negedge l_rst_n) begin
		if (!l_rst_n) begin
			st <= omr_pkg::S_IDLE;
			cnt <= 4'h0;
			sh <= 8'h00;
			rw <= 1'b0;
			first <= 1'b0;
			ptr <= 8'h00;
			sda_oe <= 1'b0;
			l_req <= 1'b0;
			l_we <= 1'b0;
			l_addr <= 8'h00;
			l_wdata <= 8'h00;
		end else if (sel_b || stop_c) begin
			st <= omr_pkg::S_IDLE;
			sda_oe <= 1'b0;
		end else if (start_c) begin
			st <= omr_pkg::S_DEV;
			cnt <= 4'h0;
			first <= 1'b1;
			sda_oe <= 1'b0;
		end else begin
			case (st)
				omr_pkg::S_DEV: begin
					if (s_rise) begin
						sh <= {sh[6:0], sda_b};
						cnt <= cnt + 4'h1;
					end else if (s_fall && cnt == 4'h8) begin
						if (sh[7:1] == DEV_ADDRESS) begin
							sda_oe <= 1'b1;
							rw <= sh[0];
							st <= omr_pkg::S_DACK;
							if (sh[0]) begin
								l_req <= ~l_req;
								l_we <= 1'b0;
								l_addr <= ptr;
							end
						end else begin
							st <= omr_pkg::S_IDLE;
						end
					end
				end
				omr_pkg::S_DACK: begin
					if (s_fall) begin
						cnt <= 4'h0;
						if (rw) begin
							sh <= rd_ok ? c_rdata : 8'hff;
							sda_oe <= rd_ok & ~c_rdata[7];
							ptr <= ptr + 8'h01;
							st <= omr_pkg::S_TX;
						end else begin
							sda_oe <= 1'b0;
							st <= omr_pkg::S_RX;
						end
					end
				end
				omr_pkg::S_RX: begin
					if (s_rise) begin
						sh <= {sh[6:0], sda_b};
						cnt <= cnt + 4'h1;
					end else if (s_fall && cnt == 4'h8) begin
						sda_oe <= 1'b1;
						st <= omr_pkg::S_RACK;
						if (first) begin
							ptr <= sh;
							first <= 1'b0;
						end else begin
							l_req <= ~l_req;
							l_we <= 1'b1;
							l_addr <= ptr;
							l_wdata <= sh;
							ptr <= ptr + 8'h01;
						end
					end
				end
				omr_pkg::S_RACK: begin
					if (s_fall) begin
						sda_oe <= 1'b0;
						cnt <= 4'h0;
						st <= omr_pkg::S_RX;
					end
				end
				omr_pkg::S_TX: begin
					if (s_fall) begin
						if (cnt == 4'h7) begin
							sda_oe <= 1'b0;
							st <= omr_pkg::S_TACK;
						end else begin
							sh <= {sh[6:0], 1'b0};
							sda_oe <= ~sh[6];
							cnt <= cnt + 4'h1;
						end
					end
				end
				omr_pkg::S_TACK: begin
					if (s_rise) begin
						if (sda_b) begin
							st <= omr_pkg::S_IDLE;
						end else begin
							l_req <= ~l_req;
							l_we <= 1'b0;
							l_addr <= ptr;
						end
					end else if (s_fall) begin
						sh <= rd_ok ? c_rdata : 8'hff;
						sda_oe <= rd_ok & ~c_rdata[7];
						ptr <= ptr + 8'h01;
						cnt <= 4'h0;
						st <= omr_pkg::S_TX;
					end
				end
				omr_pkg::S_IDLE: begin
					sda_oe <= 1'b0;
				end
				default: begin
					st <= omr_pkg::S_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// Core domain: reset and pin synchronisers
	// ************************************************************
	logic [1:0] rst_s;
	logic rst_n;
	logic [19:0] pin_a, pin_b;
	logic mrst_a, mrst_b, lp_a, lp_b;
	logic [3:0] tx_los_s, rx_los_s, tx_lol_s, rx_lol_s, fault_s;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_s <= 2'h0;
		end else begin
			rst_s <= {rst_s[0], 1'b1};
		end
	end
	assign rst_n = rst_s[1];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_a <= 20'h00000;
			pin_b <= 20'h00000;
			mrst_a <= 1'b1;
			mrst_b <= 1'b1;
			lp_a <= 1'b1;
			lp_b <= 1'b1;
		end else begin
			pin_a <= {tx_los_in, rx_los_in, tx_lol_in, rx_lol_in, tx_fault_in};
			pin_b <= pin_a;
			mrst_a <= module_reset_n;
			mrst_b <= mrst_a;
			lp_a <= low_power_select;
			lp_b <= lp_a;
		end
	end
	assign {tx_los_s, rx_los_s, tx_lol_s, rx_lol_s, fault_s} = pin_b;

	// ************************************************************
	// Core domain: request handshake
	// ************************************************************
	logic rq_a, rq_b, rq_c;
	logic new_req, rd_hit, wr_hit;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rq_a <= 1'b0;
			rq_b <= 1'b0;
			rq_c <= 1'b0;
			c_ack <= 1'b0;
		end else begin
			rq_a <= l_req;
			rq_b <= rq_a;
			rq_c <= rq_b;
			c_ack <= c_ack ^ new_req;
		end
	end
	assign new_req = rq_b ^ rq_c;
	assign rd_hit = new_req & ~l_we;
	assign wr_hit = new_req & l_we;

	// ************************************************************
	// Core domain: module reset and initialisation
	// ************************************************************
	logic [7:0] rst_cnt;
	logic soft_rst;
	logic [31:0] tmr;
	logic lp_eff, init_pending, pend_d;
	logic [7:0] pwr;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_cnt <= 8'h00;
			soft_rst <= 1'b0;
		end else if (mrst_b) begin
			rst_cnt <= 8'h00;
			soft_rst <= 1'b0;
		end else if (rst_cnt >= 8'(omr_pkg::RESET_CYCLES)) begin
			soft_rst <= 1'b1;
		end else begin
			rst_cnt <= rst_cnt + 8'h01;
		end
	end

	// Timer restarts on power-up and on release of a module reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tmr <= 32'h00000000;
		end else if (soft_rst) begin
			tmr <= 32'h00000000;
		end else if (tmr != 32'(INIT_CYC)) begin
			tmr <= tmr + 32'h00000001;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lp_eff <= 1'b1;
			init_pending <= 1'b1;
			pend_d <= 1'b1;
			high_power_on <= 1'b0;
			upper_class_on <= 1'b0;
		end else begin
			lp_eff <= pwr[omr_pkg::PWR_BYPASS_BIT] ? pwr[omr_pkg::PWR_CAP_BIT] : lp_b;
			init_pending <= (tmr != 32'(INIT_CYC)) | lp_eff | soft_rst;
			pend_d <= init_pending;
			high_power_on <= ~lp_eff;
			upper_class_on <= ~lp_eff & pwr[omr_pkg::PWR_UPPER_BIT];
		end
	end

	// ************************************************************
	// Core domain: user settings
	// ************************************************************
	logic [7:0] tx_off, sq_off, rx_off, page;
	logic [7:0] m_los, m_fault, m_lock;
	logic wr_pg3;

	assign wr_pg3 = wr_hit & (page == omr_pkg::PAGE_CTL);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_off <= omr_pkg::RST_CTL;
			pwr <= omr_pkg::RST_CTL;
			sq_off <= omr_pkg::RST_CTL;
			rx_off <= omr_pkg::RST_CTL;
			page <= omr_pkg::RST_CTL;
			m_los <= omr_pkg::RST_MASK;
			m_fault <= omr_pkg::RST_MASK;
			m_lock <= omr_pkg::RST_MASK;
		end else if (soft_rst) begin
			tx_off <= omr_pkg::RST_CTL;
			pwr <= omr_pkg::RST_CTL;
			sq_off <= omr_pkg::RST_CTL;
			rx_off <= omr_pkg::RST_CTL;
			page <= omr_pkg::RST_CTL;
			m_los <= omr_pkg::RST_MASK;
			m_fault <= omr_pkg::RST_MASK;
			m_lock <= omr_pkg::RST_MASK;
		end else if (wr_hit) begin
			case (l_addr)
				omr_pkg::OFF_TX_DISABLE: tx_off <= {4'h0, l_wdata[3:0]};
				omr_pkg::OFF_POWER_CTL: pwr <= {5'h00, l_wdata[2:0]};
				omr_pkg::OFF_MASK_LOS: m_los <= l_wdata;
				omr_pkg::OFF_MASK_FAULT: m_fault <= {4'h0, l_wdata[3:0]};
				omr_pkg::OFF_MASK_LOCK: m_lock <= l_wdata;
				omr_pkg::OFF_PAGE_SEL: page <= l_wdata;
				omr_pkg::OFF_SQUELCH_DIS: if (wr_pg3) sq_off <= l_wdata;
				omr_pkg::OFF_RX_OUT_DIS: if (wr_pg3) rx_off <= {l_wdata[7:4], 4'h0};
				default: page <= page;
			endcase
		end
	end

	// ************************************************************
	// Core domain: latched flags and read port
	// ************************************************************
	logic [7:0] los_f, lock_f;
	logic [3:0] fault_f;
	logic done_f, comp_irq, seen2, seen6;
	logic rd02, rd03, rd04, rd05, rd06;

	assign rd02 = rd_hit & (l_addr == omr_pkg::OFF_INIT_STATUS);
	assign rd03 = rd_hit & (l_addr == omr_pkg::OFF_SIGNAL_LOSS);
	assign rd04 = rd_hit & (l_addr == omr_pkg::OFF_TX_FAULT);
	assign rd05 = rd_hit & (l_addr == omr_pkg::OFF_LOCK_LOSS);
	assign rd06 = rd_hit & (l_addr == omr_pkg::OFF_INIT_DONE);

	// Live conditions win over a clearing read in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			los_f <= 8'h00;
			lock_f <= 8'h00;
			fault_f <= 4'h0;
		end else begin
			los_f <= (los_f & {8{~rd03}}) | {tx_los_s, rx_los_s};
			lock_f <= (lock_f & {8{~rd05}}) | {tx_lol_s, rx_lol_s};
			fault_f <= (fault_f & {4{~rd04}}) | fault_s;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done_f <= 1'b0;
			comp_irq <= 1'b0;
			seen2 <= 1'b0;
			seen6 <= 1'b0;
		end else if (pend_d & ~init_pending) begin
			done_f <= 1'b1;
			comp_irq <= 1'b1;
			seen2 <= 1'b0;
			seen6 <= 1'b0;
		end else begin
			done_f <= done_f & ~rd06 & ~init_pending;
			seen2 <= seen2 | (rd02 & ~init_pending);
			seen6 <= seen6 | rd06;
			if (seen2 & seen6) begin
				comp_irq <= 1'b0;
			end
		end
	end

	// Each byte is one sample taken on the request edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			c_rdata <= 8'h00;
		end else if (rd_hit) begin
			case (l_addr)
				omr_pkg::OFF_INIT_STATUS: c_rdata <= {6'h00, ~interrupt_oe, init_pending};
				omr_pkg::OFF_SIGNAL_LOSS: c_rdata <= los_f;
				omr_pkg::OFF_TX_FAULT: c_rdata <= {4'h0, fault_f};
				omr_pkg::OFF_LOCK_LOSS: c_rdata <= lock_f;
				omr_pkg::OFF_INIT_DONE: c_rdata <= {7'h00, done_f};
				omr_pkg::OFF_TX_DISABLE: c_rdata <= tx_off;
				omr_pkg::OFF_POWER_CTL: c_rdata <= pwr;
				omr_pkg::OFF_MASK_LOS: c_rdata <= m_los;
				omr_pkg::OFF_MASK_FAULT: c_rdata <= m_fault;
				omr_pkg::OFF_MASK_LOCK: c_rdata <= m_lock;
				omr_pkg::OFF_PAGE_SEL: c_rdata <= page;
				omr_pkg::OFF_SQUELCH_DIS: c_rdata <= (page == omr_pkg::PAGE_CTL) ? sq_off : 8'h00;
				omr_pkg::OFF_RX_OUT_DIS: c_rdata <= (page == omr_pkg::PAGE_CTL) ? rx_off : 8'h00;
				default: c_rdata <= 8'h00;
			endcase
		end
	end

	// ************************************************************
	// Core domain: channel control and sideband outputs
	// ************************************************************
	logic [3:0] shut, fault_p, off_p;

	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_ch
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					shut[i] <= 1'b0;
					fault_p[i] <= 1'b0;
					off_p[i] <= 1'b0;
					tx_laser_on[i] <= 1'b0;
					rx_output_on[i] <= 1'b0;
				end else begin
					fault_p[i] <= fault_s[i];
					off_p[i] <= tx_off[i];
					if (fault_s[i] & ~fault_p[i]) begin
						shut[i] <= 1'b1;
					end else if (soft_rst || (tx_off[i] != off_p[i])) begin
						shut[i] <= fault_s[i];
					end
					tx_laser_on[i] <= ~tx_off[i] & ~shut[i] & ~init_pending
						& ~(~sq_off[i] & tx_los_s[i]);
					rx_output_on[i] <= ~rx_off[4 + i]
						& ~(~sq_off[4 + i] & rx_los_s[i]);
				end
			end
		end
	endgenerate

	// Open-drain pins: output level fixed low, enable carries the state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			presence_out <= 1'b0;
			presence_oe <= 1'b1;
			interrupt_out <= 1'b0;
			interrupt_oe <= 1'b0;
		end else begin
			presence_out <= 1'b0;
			presence_oe <= 1'b1;
			interrupt_out <= 1'b0;
			interrupt_oe <= comp_irq | (|(los_f & ~m_los))
				| (|(fault_f & ~m_fault[3:0])) | (|(lock_f & ~m_lock));
		end
	end
endmodule

//--- omr_pkg.sv
// Constants for the optical module management register block
// Behaviour
// - Deselected module ignores and never acknowledges bus
// - Select input defaults high when undriven
// - Long reset pulse restores all user defaults
// - Completion interrupt posted, also after power-up
// - Low power pin defaults high, level one
// - Power set by pin and byte 93 bits
// - Presence held low whenever module inserted
// - Sideband outputs open-drain, driven low only
// - Interrupt released after status and flags read
// - Two-byte monitors returned from one coherent sample; block has no monitors
// - Threshold crossing sets flag, unmasked raises interrupt; block has no thresholds
// - Every flag has volatile mask bit; init complete flag has none
// - Byte 3 latched clear-on-read LOS flags
// - Byte 5 latched clear-on-read lock loss flags
// - Byte 4 fault flags; fault disables channel
// - Reset or disable toggle restores faulted channel
// - Byte 86 bits switch channel lasers off
// - Byte 241 high bits silence receive outputs
// - Transmit squelch default on, turns laser off
// - Receive squelch default on, silences output
// - Low power keeps pending set, complete clear
// - Functional within init interval after reset
package omr_pkg;
	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] OFF_INIT_STATUS = 8'h02;
	localparam logic [7:0] OFF_SIGNAL_LOSS = 8'h03;
	localparam logic [7:0] OFF_TX_FAULT = 8'h04;
	localparam logic [7:0] OFF_LOCK_LOSS = 8'h05;
	localparam logic [7:0] OFF_INIT_DONE = 8'h06;
	localparam logic [7:0] OFF_TX_DISABLE = 8'h56;
	localparam logic [7:0] OFF_POWER_CTL = 8'h5d;
	localparam logic [7:0] OFF_MASK_LOS = 8'h64;
	localparam logic [7:0] OFF_MASK_FAULT = 8'h65;
	localparam logic [7:0] OFF_MASK_LOCK = 8'h66;
	localparam logic [7:0] OFF_PAGE_SEL = 8'h7f;
	localparam logic [7:0] OFF_SQUELCH_DIS = 8'hf0;
	localparam logic [7:0] OFF_RX_OUT_DIS = 8'hf1;
	localparam logic [7:0] PAGE_CTL = 8'h03;
	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int PWR_BYPASS_BIT = 0;
	localparam int PWR_CAP_BIT = 1;
	localparam int PWR_UPPER_BIT = 2;
	localparam logic [7:0] RST_CTL = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [6:0] DEV_ADDR = 7'h50;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_NS = 50;
	localparam int INIT_TIME_MS = 2000;
	localparam int INIT_CYCLES = INIT_TIME_MS * (1000000 / CLK_NS);
	localparam int RESET_PULSE_US = 10;
	localparam int RESET_CYCLES = (RESET_PULSE_US * 1000 + CLK_NS - 1) / CLK_NS;
	// ************************************************************
	// Link states
	// ************************************************************
	typedef enum logic [6:0] {
		S_IDLE = 7'b0000001,
		S_DEV = 7'b0000010,
		S_DACK = 7'b0000100,
		S_RX = 7'b0001000,
		S_RACK = 7'b0010000,
		S_TX = 7'b0100000,
		S_TACK = 7'b1000000
	} omr_state_t;
endpackage

//--- omr_regs_properties.sv
// Concurrent checks on the pins of the management register block
`timescale 1ns/1ps
module omr_regs_properties #(
	parameter int INIT_CYC = omr_pkg::INIT_CYCLES,
	parameter logic [6:0] DEV_ADDRESS = omr_pkg::DEV_ADDR
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic link_clk,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic module_select_n,
	input wire logic module_reset_n,
	input wire logic low_power_select,
	input wire logic presence_out,
	input wire logic presence_oe,
	input wire logic interrupt_out,
	input wire logic [3:0] tx_fault_in,
	input wire logic [3:0] tx_laser_on,
	input wire logic high_power_on,
	input wire logic upper_class_on
);
	// ********
	// Helpers
	// ********
	// Cycles with the reset pin low; saturates so a long pulse never wraps
	logic [7:0] low_cnt;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			low_cnt <= 8'h00;
		end else if (module_reset_n) begin
			low_cnt <= 8'h00;
		end else if (low_cnt != 8'hff) begin
			low_cnt <= low_cnt + 8'h01;
		end
	end
	sequence deselected;
		module_select_n [*6];
	endsequence
	sequence long_reset_lp;
		(low_cnt == 8'hff && low_power_select) [*5];
	endsequence
	// ********
	// Assertions
	// ********
	a_presence_held: assert property (@(posedge clk) disable iff (!nrst)
		presence_oe && !presence_out) else $error("presence line released");
	a_irq_drive_low: assert property (@(posedge clk) disable iff (!nrst)
		!interrupt_out) else $error("interrupt pin driven high");
	a_sda_drive_low: assert property (@(posedge link_clk) disable iff (!nrst)
		!sda_out) else $error("data pin driven high");
	a_deselect_quiet: assert property (@(posedge link_clk) disable iff (!nrst)
		deselected |-> !sda_oe) else $error("data pulled while deselected");
	for (genvar k = 0; k < 4; k++) begin : g_ch
		a_fault_laser_off: assert property (@(posedge clk) disable iff (!nrst)
			tx_fault_in[k] [*6] |-> !tx_laser_on[k]) else $error("laser on during fault");
	end
	a_upper_needs_high: assert property (@(posedge clk) disable iff (!nrst)
		upper_class_on |-> high_power_on) else $error("upper class without high power");
	a_reset_lasers_off: assert property (@(posedge clk) disable iff (!nrst)
		low_cnt == 8'hff |-> tx_laser_on == 4'h0) else $error("laser on in module reset");
	a_reset_low_power: assert property (@(posedge clk) disable iff (!nrst)
		long_reset_lp |-> !high_power_on) else $error("high power in reset, pin high");
endmodule
bind omr_regs omr_regs_properties #(.INIT_CYC(INIT_CYC), .DEV_ADDRESS(DEV_ADDRESS)) u_props (
	.clk(clk), .nrst(nrst), .link_clk(link_clk), .sda_out(sda_out), .sda_oe(sda_oe),
	.module_select_n(module_select_n), .module_reset_n(module_reset_n),
	.low_power_select(low_power_select), .presence_out(presence_out),
	.presence_oe(presence_oe), .interrupt_out(interrupt_out), .tx_fault_in(tx_fault_in),
	.tx_laser_on(tx_laser_on), .high_power_on(high_power_on),
	.upper_class_on(upper_class_on)
);

//--- omr_host_model.sv
// Two-wire host controller model for the management bus
`timescale 1ns/1ps
module omr_host_model (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_pull
);
	// Quarter bit in core cycles: 0.8 us half periods leave room for the read fetch
	localparam int quarter = 8;
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic tick();
		repeat (quarter) @(posedge clk);
	endtask
	// Data changes only while the clock is low; sampled mid high phase
	task automatic bit_io(input logic b, output logic s);
		sda_pull <= !b;
		tick();
		scl <= 1'b1;
		tick();
		s = sda;
		tick();
		scl <= 1'b0;
		tick();
	endtask
	task automatic frame_start();
		sda_pull <= 1'b0;
		tick();
		scl <= 1'b1;
		tick();
		sda_pull <= 1'b1;
		tick();
		scl <= 1'b0;
		tick();
	endtask
	// Clock left standing high between frames
	task automatic frame_stop();
		sda_pull <= 1'b1;
		tick();
		scl <= 1'b1;
		tick();
		sda_pull <= 1'b0;
		tick();
	endtask
	task automatic put(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = (s === 1'b0);
	endtask
	task automatic get(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
		bit_io(last, s);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic k0;
		logic k1;
		logic k2;
		frame_start();
		put({omr_pkg::DEV_ADDR, 1'b0}, k0);
		put(a, k1);
		put(d, k2);
		frame_stop();
		ok = k0 & k1 & k2;
	endtask
	// Each byte fetched in its own complete sequence
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		logic k0;
		logic k1;
		logic k2;
		frame_start();
		put({omr_pkg::DEV_ADDR, 1'b0}, k0);
		put(a, k1);
		frame_start();
		put({omr_pkg::DEV_ADDR, 1'b1}, k2);
		get(1'b1, d);
		frame_stop();
		ok = k0 & k1 & k2;
	endtask
endmodule

//--- optical_module_mgmt_regs_tb_top.sv
// Self-checking bench for the optical module management register block
`timescale 1ns/1ps
module optical_module_mgmt_regs_tb_top;
	// Short init count keeps the run small
	localparam int init_n = 100;
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic nrst = 1'b0;
	logic module_select_n = 1'b1;
	logic module_reset_n = 1'b1;
	logic low_power_select = 1'b1;
	logic [3:0] tx_los_in = 4'h0;
	logic [3:0] rx_los_in = 4'h0;
	logic [3:0] tx_lol_in = 4'h0;
	logic [3:0] rx_lol_in = 4'h0;
	logic [3:0] tx_fault_in = 4'h0;
	logic scl;
	logic sda_pull;
	logic sda_oe;
	logic sda;
	logic presence_oe;
	logic interrupt_oe;
	logic [3:0] tx_laser_on;
	logic [3:0] rx_output_on;
	logic high_power_on;
	logic upper_class_on;
	logic ok;
	logic [7:0] rdata;
	int n_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [7:0] flag_off [5] = '{8'h03, 8'h03, 8'h05, 8'h05, 8'h04};
	logic [7:0] flag_val [5] = '{8'h04, 8'h40, 8'h04, 8'h40, 8'h04};
	always #25 clk = ~clk;
	initial begin
		#3;
		forever #7.5 link_clk = ~link_clk;
	end
	// Open-drain data line with pull-up
	assign sda = !(sda_pull || sda_oe);
	omr_regs #(.INIT_CYC(init_n)) dut (
		.clk(clk), .nrst(nrst), .link_clk(link_clk), .scl_in(scl), .sda_in(sda),
		.sda_out(), .sda_oe(sda_oe), .module_select_n(module_select_n),
		.module_reset_n(module_reset_n), .low_power_select(low_power_select),
		.presence_out(), .presence_oe(presence_oe), .interrupt_out(),
		.interrupt_oe(interrupt_oe), .tx_los_in(tx_los_in), .rx_los_in(rx_los_in),
		.tx_lol_in(tx_lol_in), .rx_lol_in(rx_lol_in), .tx_fault_in(tx_fault_in),
		.tx_laser_on(tx_laser_on), .rx_output_on(rx_output_on),
		.high_power_on(high_power_on), .upper_class_on(upper_class_on)
	);
	omr_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
	// ********
	// Tasks
	// ********
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		host.wr(a, d, ok);
		check(8'(ok), 8'h01);
	endtask
	task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
		host.rd(a, rdata, ok);
		check(rdata & m, exp);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wait_irq(input logic lvl);
		for (int i = 0; i < 400 && interrupt_oe !== lvl; i++) @(posedge clk);
		check(8'(interrupt_oe), 8'(lvl));
	endtask
	task automatic drive_flag(input int i, input logic [3:0] v);
		case (i)
			0: rx_los_in <= v;
			1: tx_los_in <= v;
			2: rx_lol_in <= v;
			3: tx_lol_in <= v;
			default: tx_fault_in <= v;
		endcase
	endtask
	// Hang guard, well above the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			n_errors++;
			conclude();
		end
	end
	// ********
	// Sequence
	// ********
	initial begin
		idle(2);
		nrst <= 1'b1;
		idle(5);
		check(8'(presence_oe), 8'h01);
		host.wr(8'h56, 8'h0f, ok);
		check(8'(ok), 8'h00);
		module_select_n <= 1'b0;
		idle(20 + init_n);
		reg_rd(8'h02, 8'h03);
		check(8'(high_power_on), 8'h00);
		reg_rd(8'h56, 8'h00);
		reg_rd(8'h20, 8'h00);
		reg_wr(8'h7f, 8'h03);
		reg_rd(8'hf0, 8'h00);
		reg_rd(8'hf1, 8'h00);
		reg_wr(8'h5d, 8'h05);
		idle(5);
		check(8'({high_power_on, upper_class_on}), 8'h03);
		wait_irq(1'b1);
		reg_rd(8'h02, 8'h00);
		check(8'(interrupt_oe), 8'h01);
		reg_rd(8'h06, 8'h01);
		wait_irq(1'b0);
		check(8'({tx_laser_on, rx_output_on}), 8'hff);
		for (int i = 0; i < 5; i++) begin
			drive_flag(i, 4'h4);
			idle(8);
			drive_flag(i, 4'h0);
			wait_irq(1'b1);
			reg_rd(flag_off[i], flag_val[i]);
			reg_rd(flag_off[i], 8'h00);
			wait_irq(1'b0);
		end
		// Persisting fault survives a toggle; cleared fault is restored by one
		tx_fault_in <= 4'h1;
		idle(8);
		check(8'(tx_laser_on), 8'h0a);
		reg_wr(8'h56, 8'h01);
		reg_wr(8'h56, 8'h00);
		check(8'(tx_laser_on), 8'h0a);
		tx_fault_in <= 4'h0;
		reg_rd(8'h04, 8'h01);
		reg_wr(8'h56, 8'h04);
		reg_wr(8'h56, 8'h09);
		check(8'(tx_laser_on), 8'h06);
		reg_wr(8'h56, 8'h00);
		check(8'(tx_laser_on), 8'h0f);
		rx_los_in <= 4'h1;
		idle(8);
		reg_rd(8'h03, 8'h01);
		reg_rd(8'h03, 8'h01);
		rx_los_in <= 4'h0;
		reg_rd(8'h03, 8'h01);
		reg_rd(8'h03, 8'h00);
		reg_wr(8'h64, 8'hff);
		reg_wr(8'h66, 8'hff);
		tx_los_in <= 4'h1;
		rx_los_in <= 4'h8;
		rx_lol_in <= 4'h2;
		idle(8);
		check(8'({tx_laser_on, rx_output_on}), 8'he7);
		reg_wr(8'hf0, 8'h81);
		check(8'({tx_laser_on, rx_output_on}), 8'hff);
		check(8'(interrupt_oe), 8'h00);
		tx_los_in <= 4'h0;
		rx_los_in <= 4'h0;
		rx_lol_in <= 4'h0;
		reg_wr(8'hf0, 8'h00);
		reg_wr(8'h64, 8'h00);
		wait_irq(1'b1);
		reg_rd(8'h03, 8'h18);
		check(8'(interrupt_oe), 8'h00);
		reg_wr(8'h66, 8'h00);
		wait_irq(1'b1);
		reg_rd(8'h05, 8'h02);
		reg_wr(8'hf1, 8'h50);
		check(8'(rx_output_on), 8'h0a);
		reg_wr(8'hf1, 8'h00);
		// Short reset pulse is ignored, long one restores defaults
		reg_wr(8'h56, 8'h09);
		module_reset_n <= 1'b0;
		idle(150);
		module_reset_n <= 1'b1;
		reg_rd(8'h56, 8'h09);
		module_reset_n <= 1'b0;
		idle(300);
		check(8'(tx_laser_on), 8'h00);
		module_reset_n <= 1'b1;
		reg_rd(8'h56, 8'h00);
		reg_rd(8'h5d, 8'h00);
		reg_rd(8'h02, 8'h01, 8'h01);
		low_power_select <= 1'b0;
		wait_irq(1'b1);
		reg_rd(8'h02, 8'h00, 8'h01);
		check(8'(tx_laser_on), 8'h0f);
		reg_wr(8'h5d, 8'h03);
		idle(5);
		check(8'(high_power_on), 8'h00);
		reg_rd(8'h02, 8'h01, 8'h01);
		conclude();
	end
endmodule
